// ---- rtl/pmic_spi_peripheral_port.sv ----
`timescale 1ns/10ps
module pmic_spi_peripheral_port
  import spi_port_pkg::*;
#(
  parameter int STORE_DEPTH = 16
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic spi_cs_n, // Chip select pin, active low
  input wire logic spi_sck, // Serial clock pin
  input wire logic spi_sdi, // Serial data in pin
  output logic serial_data_out, // Serial data out level
  output logic serial_data_oe, // High while data out is driven
  input wire logic driver_enable_pin, // Driver enable pin, asynchronous
  input wire logic processor_error_event, // Pulse: processor error pin event
  input wire logic thermal_warning_event, // Pulse: thermal warning event
  input wire logic watchdog_event, // Pulse: watchdog event
  input wire logic nvm_check_default, // Checksum enable default from NVM
  output logic frame_check_enable // Checksum enable configuration bit
);
  localparam int IW = $clog2(STORE_DEPTH);
  localparam logic [7:0] DEPTH_L = 8'(STORE_DEPTH);
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_DRV = 3;

  initial begin
    if (STORE_DEPTH < 2 || STORE_DEPTH > 240) begin
      $error("STORE_DEPTH must lie in 2..240 so it stays below the status address");
    end
  end

  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic sck_prev_r;
  logic cs_prev_r;
  logic [5:0] bit_cnt_r;
  logic [31:0] rx_r;
  logic [6:0] snapshot_r;
  logic [7:0] addr_r;
  logic [2:0] page_r;
  logic dir_r;
  logic hdr_pend_r;
  logic load_pend_r;
  logic chk_pend_r;
  logic [7:0] rdata_r;
  logic [7:0] rcheck_r;
  logic [5:0] flags_r;
  logic nvm_loaded_r;
  logic [7:0] store_q;

  // Every pin passes two flops; only the second stage is read below
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          pin_meta_r[g] <= (g == PIN_CS) ? 1'b1 : 1'b0;
          pin_sync_r[g] <= (g == PIN_CS) ? 1'b1 : 1'b0;
        end else begin
          pin_meta_r[g] <= (g == PIN_CS) ? spi_cs_n : (g == PIN_SCK) ? spi_sck :
                           (g == PIN_SDI) ? spi_sdi : driver_enable_pin;
          pin_sync_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sck_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= pin_sync_r[PIN_SCK];
      cs_prev_r <= pin_sync_r[PIN_CS];
    end
  end

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_low = ~pin_sync_r[PIN_CS];
  assign cs_fall = cs_low & cs_prev_r;
  assign cs_rise = pin_sync_r[PIN_CS] & ~cs_prev_r;
  assign sck_rise = cs_low & pin_sync_r[PIN_SCK] & ~sck_prev_r;
  assign sck_fall = cs_low & ~pin_sync_r[PIN_SCK] & sck_prev_r;

  logic [7:0] status_live;
  logic [15:0] status_word;
  assign status_live = {1'b0, flags_r, pin_sync_r[PIN_DRV]};
  assign status_word = {1'b0, snapshot_r, 1'b1, ~snapshot_r};

  // Counter saturates so an overlong frame cannot wrap into a legal length
  always_ff @(posedge clk_sys) begin
    if (!resetn || !cs_low) begin
      bit_cnt_r <= 6'h00;
      rx_r <= 32'h0000_0000;
    end else if (sck_rise) begin
      rx_r <= {rx_r[30:0], pin_sync_r[PIN_SDI]};
      if (bit_cnt_r != COUNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      snapshot_r <= 7'h00;
    end else if (cs_fall) begin
      snapshot_r <= status_live[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || !cs_low) begin
      hdr_pend_r <= 1'b0;
      load_pend_r <= 1'b0;
      chk_pend_r <= 1'b0;
    end else begin
      hdr_pend_r <= sck_rise && bit_cnt_r == HEADER_LAST_BIT;
      load_pend_r <= hdr_pend_r;
      chk_pend_r <= sck_rise && bit_cnt_r == STATUS_LAST_BIT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_r <= 8'h00;
      page_r <= 3'h0;
      dir_r <= DIR_WRITE;
    end else if (hdr_pend_r) begin
      addr_r <= rx_r[11:4];
      page_r <= rx_r[3:1];
      dir_r <= rx_r[0];
    end
  end

  logic in_store;
  assign in_store = page_r == STORE_PAGE && addr_r < DEPTH_L;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
      rcheck_r <= 8'h00;
    end else begin
      if (load_pend_r) begin
        if (in_store) begin
          rdata_r <= store_q;
        end else if (page_r == STORE_PAGE && addr_r == STATUS_ADDR) begin
          rdata_r <= status_live;
        end else if (page_r == STORE_PAGE && addr_r == CONFIG_ADDR) begin
          rdata_r <= {7'h00, frame_check_enable};
        end else begin
          rdata_r <= 8'h00;
        end
      end
      if (chk_pend_r) begin
        rcheck_r <= check_code({rx_r[15:0], rdata_r});
      end
    end
  end

  // Next output bit is chosen on the falling edge that ends the current bit
  always_ff @(posedge clk_sys) begin
    if (!resetn || !cs_low) begin
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      serial_data_oe <= 1'b1;
      if (cs_fall) begin
        serial_data_out <= 1'b0;
      end else if (sck_fall) begin
        if (bit_cnt_r <= STATUS_LAST_BIT) begin
          serial_data_out <= status_word[4'hF - bit_cnt_r[3:0]];
        end else if (dir_r == DIR_READ && bit_cnt_r < DATA_END_BIT) begin
          serial_data_out <= rdata_r[3'h7 - bit_cnt_r[2:0]];
        end else if (dir_r == DIR_READ && frame_check_enable && bit_cnt_r < CHECK_END_BIT) begin
          serial_data_out <= rcheck_r[3'h7 - bit_cnt_r[2:0]];
        end else begin
          serial_data_out <= 1'b0;
        end
      end
    end
  end

  // Frame is judged only when select returns high
  logic frame_ok;
  logic check_ok;
  logic [7:0] wdata;
  logic writable;
  logic commit_write;
  logic store_we;
  assign frame_ok = bit_cnt_r == (frame_check_enable ? FRAME_CHECKED_LEN : FRAME_PLAIN_LEN);
  assign wdata = frame_check_enable ? rx_r[15:8] : rx_r[7:0];
  assign check_ok = !frame_check_enable || check_code(rx_r[31:8]) == rx_r[7:0];
  assign writable = in_store || (page_r == STORE_PAGE && (addr_r == STATUS_ADDR || addr_r == CONFIG_ADDR));
  assign commit_write = cs_rise && frame_ok && dir_r == DIR_WRITE && check_ok && writable;
  assign store_we = commit_write && in_store;

  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  always_comb begin
    flag_set = 6'h00;
    flag_clr = 6'h00;
    flag_set[FLAG_ADDR_ERR] = cs_rise && frame_ok && dir_r == DIR_WRITE && check_ok && !writable;
    flag_set[FLAG_CHECK_ERR] = cs_rise && frame_ok && dir_r == DIR_WRITE && !check_ok;
    flag_set[FLAG_FRAME_ERR] = cs_rise && !frame_ok;
    flag_set[FLAG_PROC_PIN] = processor_error_event;
    flag_set[FLAG_THERMAL] = thermal_warning_event;
    flag_set[FLAG_WATCHDOG] = watchdog_event;
    if (commit_write && addr_r == STATUS_ADDR) begin
      flag_clr = wdata[6:1];
    end
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // The strap is caught on the first clock after reset release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      frame_check_enable <= 1'b0;
      nvm_loaded_r <= 1'b0;
    end else if (!nvm_loaded_r) begin
      frame_check_enable <= nvm_check_default;
      nvm_loaded_r <= 1'b1;
    end else if (commit_write && addr_r == CONFIG_ADDR) begin
      frame_check_enable <= wdata[CFG_CHECK_BIT];
    end
  end

  reg_store #(
    .DEPTH(STORE_DEPTH),
    .WIDTH(8)
  ) u_store (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .we(store_we),
    .waddr(addr_r[IW-1:0]),
    .wdata(wdata),
    .raddr(rx_r[4+IW-1:4]),
    .rdata(store_q)
  );

  a_float_when_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cs_low |=> !serial_data_oe && !serial_data_out) else $error("data out driven while deselected");
  a_first_bit_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_fall |=> serial_data_oe && !serial_data_out) else $error("first status bit not zero");
  a_status_marker: assert property (@(posedge clk_sys) disable iff (!resetn)
    sck_fall && bit_cnt_r == STATUS_MARK_BIT |=> serial_data_out) else $error("bit nine not one");
  // The copy is reloaded at the select fall, so only the cycle after a non-fall must keep it
  a_snapshot_frozen: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_low && !cs_fall |=> $stable(snapshot_r)) else $error("status copy changed mid frame");
  a_write_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    sck_fall && dir_r == DIR_WRITE && bit_cnt_r > STATUS_LAST_BIT |=> !serial_data_out)
    else $error("data out high during write data");
  a_counter_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cs_low ##1 !cs_low |-> bit_cnt_r == 6'h00) else $error("bit count kept while deselected");
  a_length_gates_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    store_we |-> bit_cnt_r == FRAME_PLAIN_LEN || bit_cnt_r == FRAME_CHECKED_LEN)
    else $error("store written by wrong-length frame");
  a_bad_length_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_rise && !frame_ok |=> flags_r[FLAG_FRAME_ERR] && $stable(frame_check_enable))
    else $error("frame error not latched");
  a_bad_check_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_rise && frame_ok && dir_r == DIR_WRITE && !check_ok |-> !store_we ##1 flags_r[FLAG_CHECK_ERR])
    else $error("bad checksum write not dropped");
  // A write-one clear right after the event is legal, so only that may drop the flag
  a_event_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    watchdog_event |=> flags_r[FLAG_WATCHDOG] ##1 (flags_r[FLAG_WATCHDOG] || $past(flag_clr[FLAG_WATCHDOG])))
    else $error("watchdog flag not latched");

  c_read_frame: cover property (@(posedge clk_sys) disable iff (!resetn) cs_rise && frame_ok && dir_r == DIR_READ);
  c_store_write: cover property (@(posedge clk_sys) disable iff (!resetn) store_we);
  c_check_error: cover property (@(posedge clk_sys) disable iff (!resetn) flag_set[FLAG_CHECK_ERR]);
  c_frame_error: cover property (@(posedge clk_sys) disable iff (!resetn) flag_set[FLAG_FRAME_ERR]);
endmodule

// ---- pkg/spi_port_pkg.sv ----
package spi_port_pkg;
  // Frame geometry, counted in serial clock bits
  localparam logic [5:0] FRAME_PLAIN_LEN = 6'h18;
  localparam logic [5:0] FRAME_CHECKED_LEN = 6'h20;
  localparam logic [5:0] HEADER_LAST_BIT = 6'h0B;
  localparam logic [5:0] STATUS_LAST_BIT = 6'h0F;
  localparam logic [5:0] STATUS_MARK_BIT = 6'h08;
  localparam logic [5:0] DATA_END_BIT = 6'h18;
  localparam logic [5:0] CHECK_END_BIT = 6'h20;
  localparam logic [5:0] COUNT_MAX = 6'h3F;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Register placement
  localparam logic [2:0] STORE_PAGE = 3'h0;
  localparam logic [7:0] STATUS_ADDR = 8'hF0;
  localparam logic [7:0] CONFIG_ADDR = 8'hF1;
  localparam int CFG_CHECK_BIT = 0;
  localparam logic [7:0] STORE_RESET = 8'h00;

  // Latched flag vector, index = status bit position minus one
  localparam int FLAG_ADDR_ERR = 5;
  localparam int FLAG_CHECK_ERR = 4;
  localparam int FLAG_FRAME_ERR = 3;
  localparam int FLAG_PROC_PIN = 2;
  localparam int FLAG_THERMAL = 1;
  localparam int FLAG_WATCHDOG = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // Checksum generator
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_INIT = 8'hFF;

  function automatic logic [7:0] check_code(input logic [23:0] bits);
    logic [7:0] crc;
    logic fb;
    crc = CHECK_INIT;
    fb = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      fb = crc[7] ^ bits[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? CHECK_POLY : 8'h00);
    end
    return crc;
  endfunction
endpackage

// ---- rtl/reg_store.sv ----
`timescale 1ns/10ps
module reg_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic we, // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] waddr, // Write index
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [$clog2(DEPTH)-1:0] raddr, // Read index
  output logic [WIDTH-1:0] rdata // Registered read data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("reg_store: DEPTH must be at least 2");
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[raddr];
    end
  end
endmodule

// ---- test/spi_ctrl_model.sv ----
`timescale 1ns/10ps
module spi_ctrl_model (
  input wire logic go, // Rising edge starts a frame
  input wire logic [5:0] nbits, // Clock count of the frame
  input wire logic [31:0] tx, // Frame bit 1 sits at [31]
  input wire logic sdo, // Device data out wire
  output logic cs_n, // Chip select, active low
  output logic sck, // Serial clock, still outside frames
  output logic sdi, // Serial data to device
  output logic [31:0] rx, // Bits seen on sdo, bit 1 at [31]
  output logic done // High once the frame has ended
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rx = 32'h0;
    done = 1'b1;
  end
  always @(posedge go) begin
    done = 1'b0;
    rx = 32'h0;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[31-i];
      #62.5 sck = 1'b1;
      rx[31-i] = sdo;
      #62.5 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    // Released data line must not look like a held bit
    sdi = ~sdi;
    #100 done = 1'b1;
  end
endmodule

// ---- test/pmic_spi_peripheral_port_tb.sv ----
`timescale 1ns/10ps
module pmic_spi_peripheral_port_tb;
  import spi_port_pkg::*;
  logic clk_sys = 0, resetn = 0, go = 0, drv = 0, pe = 0, te = 0, we = 0, nvm = 0;
  logic [5:0] nbits = 0;
  logic [5:0] ln = 6'h18;
  logic [5:0] flg = 0;
  logic [31:0] tx = 0;
  logic [31:0] rx;
  logic cs_n, sck, sdi, sdo_q, oe, cfg, done, sdo;
  int fails = 0;
  int cmp_count = 0;
  // No pull on the line: a released pin shows the inverse so a late enable cannot pass
  assign sdo = oe ? sdo_q : ~sdo_q;
  initial forever #5 clk_sys = ~clk_sys;
  pmic_spi_peripheral_port DUT (.clk_sys(clk_sys), .resetn(resetn), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_sdi(sdi), .serial_data_out(sdo_q), .serial_data_oe(oe), .driver_enable_pin(drv),
    .processor_error_event(pe), .thermal_warning_event(te), .watchdog_event(we),
    .nvm_check_default(nvm), .frame_check_enable(cfg));
  spi_ctrl_model PEER (.go(go), .nbits(nbits), .tx(tx), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .rx(rx), .done(done));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [23:0] b);
    logic [7:0] c;
    c = CHECK_INIT;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CHECK_POLY : 8'h00);
    return c;
  endfunction

  task automatic xfer(input logic [7:0] a, input logic [2:0] pg, input logic dir, input logic [7:0] d,
                      input logic [5:0] n, input logic bad);
    logic [23:0] h;
    logic [6:0] s;
    h = {a, pg, dir, 4'h0, d};
    @(posedge clk_sys);
    s = {flg, drv};
    tx <= {h, crc8(h) ^ {7'h0, bad}};
    nbits <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < 1000 && done !== 1'b1; i++) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
    check(rx[31:16], {1'b0, s, 1'b1, ~s});
    check(oe, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, STORE_PAGE, DIR_WRITE, d, ln, 1'b0);
    check(rx[15:8], 8'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(a, STORE_PAGE, DIR_READ, 8'h00, ln, 1'b0);
    check(rx[15:8], exp);
    if (ln == FRAME_CHECKED_LEN) check(rx[7:0], crc8({tx[31:16], exp}));
  endtask

  task automatic give_verdict;
    $display("compares=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(cfg, 1'b0);
    check(oe, 1'b0);
    wr(8'h03, 8'hA5);
    rd(8'h03, 8'hA5);
    rd(8'h0F, STORE_RESET);
    $display("test store done");
    drv <= 1'b1;
    pe <= 1'b1;
    we <= 1'b1;
    @(posedge clk_sys);
    pe <= 1'b0;
    we <= 1'b0;
    flg = 6'h05;
    // Thermal event lands mid-frame; snapshot must not move
    fork
      rd(8'h03, 8'hA5);
      begin
        repeat (40) @(posedge clk_sys);
        te <= 1'b1;
        @(posedge clk_sys);
        te <= 1'b0;
      end
    join
    flg[FLAG_THERMAL] = 1'b1;
    rd(STATUS_ADDR, {1'b0, flg, drv});
    drv <= 1'b0;
    wr(STATUS_ADDR, 8'h0C);
    flg = 6'h01;
    rd(STATUS_ADDR, {1'b0, flg, drv});
    $display("test status done");
    xfer(8'h04, STORE_PAGE, DIR_WRITE, 8'h5A, 6'h17, 1'b0);
    flg[FLAG_FRAME_ERR] = 1'b1;
    xfer(8'h04, STORE_PAGE, DIR_WRITE, 8'h5A, 6'h19, 1'b0);
    rd(8'h04, 8'h00);
    xfer(8'h03, 3'h1, DIR_WRITE, 8'h11, ln, 1'b0);
    flg[FLAG_ADDR_ERR] = 1'b1;
    rd(8'h03, 8'hA5);
    wr(STATUS_ADDR, 8'h7E);
    flg = 6'h00;
    $display("test frame done");
    wr(CONFIG_ADDR, 8'h01);
    check(cfg, 1'b1);
    ln = FRAME_CHECKED_LEN;
    rd(CONFIG_ADDR, 8'h01);
    wr(8'h05, 8'h3C);
    rd(8'h05, 8'h3C);
    xfer(8'h05, STORE_PAGE, DIR_WRITE, 8'hC3, ln, 1'b1);
    flg[FLAG_CHECK_ERR] = 1'b1;
    rd(8'h05, 8'h3C);
    xfer(8'h05, STORE_PAGE, DIR_WRITE, 8'hC3, FRAME_PLAIN_LEN, 1'b0);
    flg[FLAG_FRAME_ERR] = 1'b1;
    rd(8'h05, 8'h3C);
    $display("test checksum done");
    nvm <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(cfg, 1'b1);
    flg = 6'h00;
    rd(8'h05, STORE_RESET);
    $display("test nvm default done");
    give_verdict;
  end
endmodule
